// >>> adc_acq_pkg.sv
`default_nettype none
package adc_acq_pkg;
  // clock and rate limits
  localparam int CLK_HZ = 250_000_000;
  localparam int CONT_MAX_HZ = 30_000;
  localparam int N_MAX_HZ = 200_000;
  localparam int SYNC_MAX_HZ = 2_000;
  localparam int CONT_MIN_CYC = (CLK_HZ + CONT_MAX_HZ - 1) / CONT_MAX_HZ;
  localparam int N_MIN_CYC = (CLK_HZ + N_MAX_HZ - 1) / N_MAX_HZ;
  localparam int SYNC_MIN_CYC = (CLK_HZ + SYNC_MAX_HZ - 1) / SYNC_MAX_HZ;
  // sample buffer depth in words
  localparam logic [24:0] BUF_DEPTH = 25'h1c9c380;
  localparam logic [2:0] LAST_CH = 3'h7;
  // register word indices
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_MODE = 5'h01;
  localparam logic [4:0] REG_PERIOD = 5'h02;
  localparam logic [4:0] REG_NCOUNT = 5'h03;
  localparam logic [4:0] REG_DELAY = 5'h04;
  localparam logic [4:0] REG_THR = 5'h05;
  localparam logic [4:0] REG_FRAME = 5'h06;
  localparam logic [4:0] REG_DOUT = 5'h07;
  localparam logic [4:0] REG_STATUS = 5'h08;
  localparam logic [4:0] REG_LIVE0 = 5'h09;
  localparam logic [4:0] REG_LATCH0 = 5'h0e;
  localparam logic [4:0] REG_LAST = 5'h12;
  // control command bits
  localparam int CTRL_START = 0;
  localparam int CTRL_STOP = 1;
  localparam int CTRL_XFER = 2;
  localparam int CTRL_CLR_ERR = 3;
  // mode field positions
  localparam int MODE_SRC = 0;
  localparam int MODE_EVT = 2;
  localparam int MODE_THR = 4;
  localparam int MODE_NMODE = 6;
  localparam int MODE_PINCNT = 7;
  localparam int MODE_SYNC = 8;
  localparam int MODE_LATCH = 9;
  localparam int MODE_CH = 10;
  localparam int MODE_W = 13;
  // frame selection bits and status error bit
  localparam int FR_AI = 0;
  localparam int FR_DIO = 1;
  localparam int FR_LS = 2;
  localparam int FR_HS = 3;
  localparam int STATUS_ERR = 8;
  // emitter slots
  localparam logic [2:0] SLOT_DIO = 3'h1;
  localparam logic [2:0] SLOT_LS_LAST = 3'h5;
  localparam logic [2:0] SLOT_HS = 3'h6;
  // enumerations
  typedef enum logic [1:0] {SRC_SW = 2'h0, SRC_EVENT = 2'h1, SRC_THR = 2'h2, SRC_EXTCLK = 2'h3} src_t;
  typedef enum logic [1:0] {EVT_PRE = 2'h0, EVT_POST = 2'h1, EVT_DELAY = 2'h2, EVT_RSVD = 2'h3} evt_t;
  typedef enum logic [1:0] {THR_ABOVE = 2'h0, THR_BELOW = 2'h1, THR_LEAVE = 2'h2, THR_ENTER = 2'h3} thr_t;
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01, ST_ARMED = 6'h02, ST_WAIT = 6'h04,
    ST_RUN = 6'h08, ST_DONE = 6'h10, ST_XFER = 6'h20
  } state_t;
endpackage : adc_acq_pkg
`default_nettype wire

// >>> adc_acq_ctrl.sv
// Function
// RULE1 - continuous mode streams samples, 30 kHz max
// RULE2 - n-sample mode buffers until transfer command
// RULE3 - buffer holds thirty million samples
// RULE4 - acquisition begins only on start command
// RULE5 - falling trigger edge starts n samples
// RULE6 - one conversion per external clock fall
// RULE7 - pre-trigger hands buffered n samples over
// RULE8 - post-trigger captures only after trigger edge
// RULE9 - delay-trigger waits programmed delay, then captures
// RULE10 - capture when channel rises above high
// RULE11 - capture when channel falls below low
// RULE12 - capture when channel leaves band
// RULE13 - capture when channel enters band
// RULE14 - latch all counters at each sample point
// RULE15 - live counters readable at any time
// RULE16 - high-speed counter counts trigger pin
// RULE17 - counter use of pin blocks external modes
// RULE18 - sync frames carry host-selected input mix
// RULE19 - sync frame sampling limited to 2 kHz
// RULE20 - triggers ignored during capture until restart
// RULE21 - outside pulses meet minimum low width
// RULE22 - counters 32 bits wide
//
// The address map and register access over Avalon-MM were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module adc_acq_ctrl #(
  parameter int CONT_MIN = adc_acq_pkg::CONT_MIN_CYC,
  parameter int NMODE_MIN = adc_acq_pkg::N_MIN_CYC,
  parameter int SYNC_MIN = adc_acq_pkg::SYNC_MIN_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // avalon-mm slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // pins
  input wire logic trig_pin,
  input wire logic [3:0] di_pin,
  output logic [3:0] do_pin,
  // converter
  output logic adc_start,
  input wire logic adc_valid,
  input wire logic [15:0] adc_data,
  // sample memory
  output logic mem_we,
  output logic mem_re,
  output logic [24:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_rvalid,
  // host stream
  output logic st_valid,
  output logic [31:0] st_data
);
  adc_acq_pkg::state_t state_q, state_d;
  logic [31:0] readdata_q, period_q, ncount_q, delay_q, dly_cnt_q, per_cnt_q, scans_q;
  logic wait_q, err_q, adc_start_q, mem_we_q, mem_re_q, st_valid_q;
  logic [adc_acq_pkg::MODE_W-1:0] mode_q;
  logic [15:0] thr_hi_q, thr_lo_q, mem_wdata_q;
  logic [3:0] frame_q, do_q, di_s1_q, di_s2_q, di_s3_q;
  logic trig_s1_q, trig_s2_q, trig_s3_q;
  logic [31:0] ls_cnt_q [0:3];
  logic [31:0] ls_lat_q [0:3];
  logic [31:0] hs_cnt_q, hs_lat_q, st_data_q;
  logic [24:0] wptr_q, rptr_q, rd_left_q, run_words_q, mem_addr_q;
  logic [2:0] ai_idx_q, emit_q;
  logic prev_ok_q, prev_above_q, prev_below_q;

  // bus decode, access completes one cycle after it is raised
  wire bus_go = (avs_read | avs_write) & wait_q;
  wire wr_go = avs_write & ~wait_q;
  wire ctrl_wr = wr_go & (avs_address == adc_acq_pkg::REG_CTRL);
  wire start_cmd = ctrl_wr & avs_writedata[adc_acq_pkg::CTRL_START];
  wire stop_cmd = ctrl_wr & avs_writedata[adc_acq_pkg::CTRL_STOP];
  wire xfer_cmd = ctrl_wr & avs_writedata[adc_acq_pkg::CTRL_XFER];
  wire clr_err = ctrl_wr & avs_writedata[adc_acq_pkg::CTRL_CLR_ERR];

  // mode fields
  wire [1:0] src = mode_q[adc_acq_pkg::MODE_SRC +: 2];
  wire [1:0] evt = mode_q[adc_acq_pkg::MODE_EVT +: 2];
  wire [1:0] thr = mode_q[adc_acq_pkg::MODE_THR +: 2];
  wire n_mode = mode_q[adc_acq_pkg::MODE_NMODE];
  wire pin_cnt = mode_q[adc_acq_pkg::MODE_PINCNT];
  wire sync_fr = mode_q[adc_acq_pkg::MODE_SYNC];
  wire latch_en = mode_q[adc_acq_pkg::MODE_LATCH];
  wire [2:0] thr_ch = mode_q[adc_acq_pkg::MODE_CH +: 3];
  wire is_ext = (src == adc_acq_pkg::SRC_EXTCLK);
  wire is_evt = (src == adc_acq_pkg::SRC_EVENT);
  wire is_pre = is_evt & (evt == adc_acq_pkg::EVT_PRE);
  wire st_idle = (state_q == adc_acq_pkg::ST_IDLE);
  wire st_armed = (state_q == adc_acq_pkg::ST_ARMED);
  wire st_run = (state_q == adc_acq_pkg::ST_RUN);
  wire st_xfer = (state_q == adc_acq_pkg::ST_XFER);

  // RULE17 refuse pin modes
  wire ext_blocked = pin_cnt & (is_evt | is_ext);
  wire refused = start_cmd & st_idle & ext_blocked;

  // RULE21 edge after synchroniser
  wire trig_fall = trig_s3_q & ~trig_s2_q;
  wire [3:0] di_rise = di_s2_q & ~di_s3_q;

  // RULE19 rate floor per mode
  wire [31:0] min_cyc = sync_fr ? 32'(SYNC_MIN) : (n_mode ? 32'(NMODE_MIN) : 32'(CONT_MIN));
  wire [31:0] eff_per = (period_q > min_cyc) ? period_q : min_cyc;

  // paced sampling, pre and threshold also sample while armed
  wire pace_on = ~is_ext & (st_run | (st_armed & (is_pre | src == adc_acq_pkg::SRC_THR)));
  wire tick = pace_on & (per_cnt_q == 32'h0);
  // RULE6 one start per fall
  wire ext_tick = is_ext & st_run & ~pin_cnt & trig_fall;
  wire start_now = tick | ext_tick;

  // threshold evaluation on the selected channel
  wire sel_smp = adc_valid & (ai_idx_q == thr_ch);
  wire above = $signed(adc_data) > $signed(thr_hi_q);
  wire below = $signed(adc_data) < $signed(thr_lo_q);
  wire prev_in = ~prev_above_q & ~prev_below_q;
  wire now_in = ~above & ~below;
  // RULE10 rise above high
  wire hit_above = above & ~prev_above_q;
  // RULE11 fall below low
  wire hit_below = below & ~prev_below_q;
  // RULE12 band exit
  wire hit_leave = prev_in & ~now_in;
  // RULE13 band entry
  wire hit_enter = ~prev_in & now_in;
  wire thr_sel = (thr == adc_acq_pkg::THR_ABOVE) ? hit_above :
                 (thr == adc_acq_pkg::THR_BELOW) ? hit_below :
                 (thr == adc_acq_pkg::THR_LEAVE) ? hit_leave : hit_enter;
  wire thr_hit = sel_smp & prev_ok_q & thr_sel;
  // RULE5 falling edge trigger
  wire evt_hit = is_evt & ~pin_cnt & trig_fall;
  // RULE20 triggers only while armed
  wire trig_hit = st_armed & ((src == adc_acq_pkg::SRC_THR) ? thr_hit : evt_hit);

  // scan bookkeeping
  wire scan_end = adc_valid & (ai_idx_q == adc_acq_pkg::LAST_CH);
  wire n_reached = st_run & n_mode & ~is_ext & scan_end & (scans_q + 32'h1 >= ncount_q);
  wire [24:0] nwords = {ncount_q[21:0], 3'h0};
  wire [24:0] pre_base = (wptr_q >= nwords) ? wptr_q - nwords : wptr_q + adc_acq_pkg::BUF_DEPTH - nwords;
  // RULE3 circular buffer wrap
  wire [24:0] wptr_nx = (wptr_q == adc_acq_pkg::BUF_DEPTH - 25'h1) ? 25'h0 : wptr_q + 25'h1;
  wire [24:0] rptr_nx = (rptr_q == adc_acq_pkg::BUF_DEPTH - 25'h1) ? 25'h0 : rptr_q + 25'h1;
  // RULE2 store while buffering
  wire buf_wr = adc_valid & n_mode & (st_run | (st_armed & is_pre));
  wire rd_issue = st_xfer & (rd_left_q != 25'h0);

  // RULE1 direct streaming when continuous
  wire ai_live = st_run & ~n_mode & adc_valid;
  // RULE18 frame content selection
  wire ai_fwd = ai_live & (~sync_fr | frame_q[adc_acq_pkg::FR_AI]);
  wire emit_on = emit_q != 3'h0;
  wire emit_ls = (emit_q > adc_acq_pkg::SLOT_DIO) & (emit_q <= adc_acq_pkg::SLOT_LS_LAST);
  wire [1:0] ls_idx = 2'(emit_q - 3'h2);
  wire emit_fire = (emit_q == adc_acq_pkg::SLOT_DIO) ? frame_q[adc_acq_pkg::FR_DIO] :
                   emit_ls ? frame_q[adc_acq_pkg::FR_LS] :
                   (emit_q == adc_acq_pkg::SLOT_HS) ? frame_q[adc_acq_pkg::FR_HS] : 1'b0;
  wire [31:0] emit_word = (emit_q == adc_acq_pkg::SLOT_DIO) ? {24'h0, do_q, di_s2_q} :
                          emit_ls ? ls_lat_q[ls_idx] : hs_lat_q;
  wire st_vld_d = mem_rvalid | ai_fwd | emit_fire;
  wire [31:0] st_dat_d = mem_rvalid ? {16'h0, mem_rdata} :
                         ai_fwd ? {13'h0, ai_idx_q, adc_data} : emit_word;

  // read map, unmapped words read zero
  wire [31:0] rmap [0:18];
  assign rmap[0] = 32'h0;
  assign rmap[1] = {19'h0, mode_q};
  assign rmap[2] = period_q;
  assign rmap[3] = ncount_q;
  assign rmap[4] = delay_q;
  assign rmap[5] = {thr_hi_q, thr_lo_q};
  assign rmap[6] = {28'h0, frame_q};
  assign rmap[7] = {28'h0, do_q};
  assign rmap[8] = {23'h0, err_q, 2'h0, state_q};
  // RULE15 live counter reads
  assign rmap[9] = ls_cnt_q[0];
  assign rmap[10] = ls_cnt_q[1];
  assign rmap[11] = ls_cnt_q[2];
  assign rmap[12] = ls_cnt_q[3];
  assign rmap[13] = hs_cnt_q;
  assign rmap[14] = ls_lat_q[0];
  assign rmap[15] = ls_lat_q[1];
  assign rmap[16] = ls_lat_q[2];
  assign rmap[17] = ls_lat_q[3];
  assign rmap[18] = hs_lat_q;
  wire [31:0] rd_mux = (avs_address <= adc_acq_pkg::REG_LAST) ? rmap[avs_address] : 32'h0;

  // next state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      adc_acq_pkg::ST_IDLE: begin
        // RULE4 start command needed
        if (start_cmd & ~ext_blocked) begin
          state_d = (src == adc_acq_pkg::SRC_SW || is_ext) ? adc_acq_pkg::ST_RUN : adc_acq_pkg::ST_ARMED;
        end
      end
      adc_acq_pkg::ST_ARMED: begin
        if (stop_cmd) begin
          state_d = adc_acq_pkg::ST_IDLE;
        end else if (trig_hit) begin
          // RULE7 pre hands over
          if (is_pre) begin
            state_d = adc_acq_pkg::ST_DONE;
          // RULE9 delay first
          end else if (is_evt && evt == adc_acq_pkg::EVT_DELAY) begin
            state_d = adc_acq_pkg::ST_WAIT;
          // RULE8 post starts now
          end else begin
            state_d = adc_acq_pkg::ST_RUN;
          end
        end
      end
      adc_acq_pkg::ST_WAIT: begin
        if (stop_cmd) begin
          state_d = adc_acq_pkg::ST_IDLE;
        end else if (dly_cnt_q == 32'h0) begin
          state_d = adc_acq_pkg::ST_RUN;
        end
      end
      adc_acq_pkg::ST_RUN: begin
        if (n_reached | stop_cmd) begin
          state_d = n_mode ? adc_acq_pkg::ST_DONE : adc_acq_pkg::ST_IDLE;
        end
      end
      adc_acq_pkg::ST_DONE: begin
        if (xfer_cmd) begin
          state_d = adc_acq_pkg::ST_XFER;
        end else if (stop_cmd) begin
          state_d = adc_acq_pkg::ST_IDLE;
        end
      end
      adc_acq_pkg::ST_XFER: begin
        if ((rd_left_q == 25'h1) | stop_cmd) begin
          state_d = adc_acq_pkg::ST_IDLE;
        end
      end
      default: state_d = adc_acq_pkg::ST_IDLE;
    endcase
  end

  // bus slave and configuration
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wait_q <= 1'b1;
      readdata_q <= 32'h0;
      mode_q <= '0;
      period_q <= 32'h0;
      ncount_q <= 32'h1;
      delay_q <= 32'h0;
      thr_hi_q <= 16'h0;
      thr_lo_q <= 16'h0;
      frame_q <= 4'h1;
      do_q <= 4'h0;
    end else begin
      wait_q <= ~(avs_read | avs_write) | ~wait_q;
      if (bus_go) begin
        readdata_q <= avs_read ? rd_mux : 32'h0;
      end
      if (wr_go && avs_address == adc_acq_pkg::REG_MODE) mode_q <= avs_writedata[adc_acq_pkg::MODE_W-1:0];
      if (wr_go && avs_address == adc_acq_pkg::REG_PERIOD) period_q <= avs_writedata;
      if (wr_go && avs_address == adc_acq_pkg::REG_NCOUNT) ncount_q <= avs_writedata;
      if (wr_go && avs_address == adc_acq_pkg::REG_DELAY) delay_q <= avs_writedata;
      if (wr_go && avs_address == adc_acq_pkg::REG_THR) begin
        thr_hi_q <= avs_writedata[31:16];
        thr_lo_q <= avs_writedata[15:0];
      end
      if (wr_go && avs_address == adc_acq_pkg::REG_FRAME) frame_q <= avs_writedata[3:0];
      if (wr_go && avs_address == adc_acq_pkg::REG_DOUT) do_q <= avs_writedata[3:0];
    end
  end

  // pin synchronisers
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      {trig_s1_q, trig_s2_q, trig_s3_q} <= 3'h7;
      di_s1_q <= 4'h0;
      di_s2_q <= 4'h0;
      di_s3_q <= 4'h0;
    end else begin
      {trig_s1_q, trig_s2_q, trig_s3_q} <= {trig_pin, trig_s1_q, trig_s2_q};
      di_s1_q <= di_pin;
      di_s2_q <= di_s1_q;
      di_s3_q <= di_s2_q;
    end
  end

  // RULE22 32-bit low-speed counters
  for (genvar i = 0; i < 4; i++) begin : g_ls
    always_ff @(posedge clk_sys) begin
      if (srst) begin
        ls_cnt_q[i] <= 32'h0;
        ls_lat_q[i] <= 32'h0;
      end else begin
        if (di_rise[i]) ls_cnt_q[i] <= ls_cnt_q[i] + 32'h1;
        // RULE14 latch at sample point
        if (start_now & latch_en) ls_lat_q[i] <= ls_cnt_q[i];
      end
    end
  end

  // RULE16 high-speed counter on trigger pin
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      hs_cnt_q <= 32'h0;
      hs_lat_q <= 32'h0;
    end else begin
      if (pin_cnt & trig_fall) hs_cnt_q <= hs_cnt_q + 32'h1;
      // RULE14 latch with samples
      if (start_now & latch_en) hs_lat_q <= hs_cnt_q;
    end
  end

  // sequencing, pacing and threshold history
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_q <= adc_acq_pkg::ST_IDLE;
      err_q <= 1'b0;
      per_cnt_q <= 32'h0;
      dly_cnt_q <= 32'h0;
      scans_q <= 32'h0;
      ai_idx_q <= 3'h0;
      adc_start_q <= 1'b0;
      prev_ok_q <= 1'b0;
      prev_above_q <= 1'b0;
      prev_below_q <= 1'b0;
    end else begin
      state_q <= state_d;
      err_q <= refused | (err_q & ~clr_err);
      adc_start_q <= start_now;
      per_cnt_q <= ~pace_on ? 32'h0 : (tick ? eff_per - 32'h1 : per_cnt_q - 32'h1);
      // RULE9 delay countdown
      dly_cnt_q <= (trig_hit & st_armed) ? delay_q : (dly_cnt_q != 32'h0 ? dly_cnt_q - 32'h1 : 32'h0);
      if (st_idle) ai_idx_q <= 3'h0;
      else if (adc_valid) ai_idx_q <= ai_idx_q + 3'h1;
      if (~st_run) scans_q <= 32'h0;
      else if (scan_end) scans_q <= scans_q + 32'h1;
      if (~st_armed) prev_ok_q <= 1'b0;
      else if (sel_smp) prev_ok_q <= 1'b1;
      if (sel_smp) begin
        prev_above_q <= above;
        prev_below_q <= below;
      end
    end
  end

  // memory access and host stream
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wptr_q <= 25'h0;
      rptr_q <= 25'h0;
      rd_left_q <= 25'h0;
      run_words_q <= 25'h0;
      mem_we_q <= 1'b0;
      mem_re_q <= 1'b0;
      mem_addr_q <= 25'h0;
      mem_wdata_q <= 16'h0;
      st_valid_q <= 1'b0;
      st_data_q <= 32'h0;
      emit_q <= 3'h0;
    end else begin
      mem_we_q <= buf_wr;
      mem_re_q <= rd_issue;
      mem_wdata_q <= adc_data;
      if (buf_wr) begin
        mem_addr_q <= wptr_q;
        wptr_q <= wptr_nx;
      end else if (rd_issue) begin
        mem_addr_q <= rptr_q;
      end
      if (state_d == adc_acq_pkg::ST_RUN && !st_run) begin
        rptr_q <= wptr_q;
        run_words_q <= 25'h0;
      end else if (st_run & buf_wr) begin
        run_words_q <= run_words_q + 25'h1;
      end else if (trig_hit & is_pre) begin
        rptr_q <= pre_base;
      end else if (rd_issue) begin
        rptr_q <= rptr_nx;
      end
      // RULE2 release on transfer command
      if (xfer_cmd & (state_q == adc_acq_pkg::ST_DONE)) begin
        rd_left_q <= is_pre ? nwords : run_words_q;
      end else if (rd_issue) begin
        rd_left_q <= rd_left_q - 25'h1;
      end
      st_valid_q <= st_vld_d;
      st_data_q <= st_dat_d;
      // RULE18 extra frame words after scan
      if (ai_live & sync_fr & scan_end) emit_q <= adc_acq_pkg::SLOT_DIO;
      else if (emit_on) emit_q <= (emit_q == adc_acq_pkg::SLOT_HS) ? 3'h0 : emit_q + 3'h1;
    end
  end

  // outputs
  assign avs_readdata = readdata_q;
  assign avs_waitrequest = wait_q;
  assign do_pin = do_q;
  assign adc_start = adc_start_q;
  assign mem_we = mem_we_q;
  assign mem_re = mem_re_q;
  assign mem_addr = mem_addr_q;
  assign mem_wdata = mem_wdata_q;
  assign st_valid = st_valid_q;
  assign st_data = st_data_q;
endmodule : adc_acq_ctrl
`default_nettype wire

// >>> adc_acq_model.sv
`timescale 1ns/1ns
`default_nettype none
module adc_acq_model (
  // clock
  input wire logic clk_sys,
  // converter side
  input wire logic adc_start,
  input wire logic [15:0] ai_level,
  output logic adc_valid,
  output logic [15:0] adc_data,
  // memory side
  input wire logic mem_we,
  input wire logic mem_re,
  input wire logic [24:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  output logic [15:0] mem_rdata,
  output logic mem_rvalid
);
  logic [15:0] mem_q [256];
  logic [3:0] cnt_q;
  logic [2:0] ch_q;
  initial begin
    cnt_q = 4'h0;
    ch_q = 3'h0;
    adc_valid = 1'b0;
    adc_data = 16'h0;
    mem_rvalid = 1'b0;
    mem_rdata = 16'h0;
  end
  // one scan per start
  // eight words per scan, level plus channel; bus toggles when idle
  always @(posedge clk_sys) begin
    adc_valid <= cnt_q > 4'h1;
    adc_data <= (cnt_q > 4'h1) ? ai_level + 16'(ch_q) : ~adc_data;
    if (cnt_q > 4'h1) ch_q <= ch_q + 3'h1;
    if (adc_start) cnt_q <= 4'h9;
    else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
  end
  // sample memory, one cycle read latency
  always @(posedge clk_sys) begin
    if (mem_we) mem_q[mem_addr[7:0]] <= mem_wdata;
    mem_rvalid <= mem_re;
    mem_rdata <= mem_re ? mem_q[mem_addr[7:0]] : ~mem_rdata;
  end
endmodule : adc_acq_model
`default_nettype wire

// >>> adc_acq_ctrl_sva.sv
`timescale 1ns/1ns
`default_nettype none
module adc_acq_ctrl_sva #(parameter int NMODE_MIN = 4) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // bus
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  // datapath
  input wire logic adc_start,
  input wire logic adc_valid,
  input wire logic [15:0] adc_data,
  input wire logic mem_we,
  input wire logic mem_re,
  input wire logic [24:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_rvalid,
  input wire logic st_valid,
  input wire logic [31:0] st_data
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  logic [7:0] gap_q;
  logic seen_q;
  // cycles since the last scan start
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      gap_q <= 8'h0;
      seen_q <= 1'b0;
    end else begin
      seen_q <= seen_q | adc_start;
      gap_q <= adc_start ? 8'h1 : gap_q + 8'(gap_q != 8'hff);
    end
  end
  sequence bus_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence bus_ack;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  chk_bus_answer: assert property (bus_req |=> bus_ack)
    else $error("bus not answered");
  chk_bus_quiet: assert property (!(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest)
    else $error("ack without request");
  chk_scan_pulse: assert property (adc_start |=> !adc_start)
    else $error("start pulse too long");
  chk_scan_gap: assert property (adc_start && seen_q |-> gap_q >= NMODE_MIN)
    else $error("scan starts too close");
  chk_buf_word: assert property (mem_we |-> $past(adc_valid) && mem_wdata == $past(adc_data))
    else $error("bad buffer write");
  chk_ai_word: assert property (st_valid && $past(adc_valid) |-> st_data[15:0] == $past(adc_data))
    else $error("streamed sample differs");
  chk_xfer_word: assert property (mem_rvalid |=> st_valid && st_data == {16'h0, $past(mem_rdata)})
    else $error("xfer word lost");
  chk_addr_range: assert property (mem_we |-> mem_addr < adc_acq_pkg::BUF_DEPTH)
    else $error("address out of range");
  chk_reset_idle: assert property (@(posedge clk_sys) disable iff (1'b0)
    srst |=> avs_waitrequest && !adc_start && !st_valid && !mem_we && !mem_re)
    else $error("activity during reset");
endmodule : adc_acq_ctrl_sva
bind adc_acq_ctrl adc_acq_ctrl_sva #(.NMODE_MIN(NMODE_MIN)) chk_u (.clk_sys, .srst, .avs_read, .avs_write,
  .avs_waitrequest, .adc_start, .adc_valid, .adc_data, .mem_we, .mem_re, .mem_addr, .mem_wdata, .mem_rdata,
  .mem_rvalid, .st_valid, .st_data);
`default_nettype wire

// >>> tb_adc_acquisition_trigger_control.sv
`timescale 1ns/1ns
`default_nettype none
module tb_adc_acquisition_trigger_control;
  logic clk_sys, srst, avs_read, avs_write, avs_waitrequest, trig_pin, adc_start, adc_valid;
  logic mem_we, mem_re, mem_rvalid, st_valid;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, st_data, rdq, w;
  logic [3:0] di_pin, do_pin;
  logic [15:0] adc_data, mem_wdata, mem_rdata, ai_level;
  logic [24:0] mem_addr;
  int err_total = 0, compares = 0, n_st = 0, n_sc = 0;
  adc_acq_ctrl #(.CONT_MIN(8), .NMODE_MIN(4), .SYNC_MIN(16)) dut_u (.clk_sys, .srst, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .trig_pin, .di_pin, .do_pin, .adc_start,
    .adc_valid, .adc_data, .mem_we, .mem_re, .mem_addr, .mem_wdata, .mem_rdata, .mem_rvalid, .st_valid, .st_data);
  adc_acq_model far_u (.clk_sys, .adc_start, .ai_level, .adc_valid, .adc_data, .mem_we, .mem_re, .mem_addr,
    .mem_wdata, .mem_rdata, .mem_rvalid);
  // clock
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // stream word and scan start counters
  always @(posedge clk_sys) begin
    if (st_valid === 1'b1) n_st++;
    if (adc_start === 1'b1) n_sc++;
  end
  task automatic tally_and_finish();
    if (err_total == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  // one avalon access, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
    rdq = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic getw();
    @(posedge clk_sys);
    while (st_valid !== 1'b1) @(posedge clk_sys);
    w = st_data;
  endtask : getw
  task automatic waitst(input logic [5:0] s);
    int n = 0;
    do begin
      bus(1'b0, adc_acq_pkg::REG_STATUS, 32'h0);
      n++;
    end while (rdq[5:0] !== s && n < 300);
    chk({26'h0, rdq[5:0]}, {26'h0, s});
  endtask : waitst
  // trigger held low past the minimum width; m is cycles to first scan start
  task automatic pulse(output int m);
    m = -1;
    @(posedge clk_sys);
    trig_pin <= 1'b0;
    for (int i = 1; i <= 400; i++) begin
      @(posedge clk_sys);
      if (adc_start === 1'b1 && m < 0) m = i;
    end
    trig_pin <= 1'b1;
    repeat (400) @(posedge clk_sys);
  endtask : pulse
  task automatic t_regs();
    bus(1'b0, adc_acq_pkg::REG_NCOUNT, 32'h0);
    chk(rdq, 32'h1);
    bus(1'b0, adc_acq_pkg::REG_FRAME, 32'h0);
    chk(rdq, 32'h1);
    bus(1'b1, 5'h1f, 32'hffff_ffff);
    bus(1'b0, 5'h1f, 32'h0);
    chk(rdq, 32'h0);
    bus(1'b1, adc_acq_pkg::REG_PERIOD, 32'd20);
    waitst(6'h01);
  endtask : t_regs
  task automatic t_cont();
    bus(1'b1, adc_acq_pkg::REG_MODE, 32'h0);
    repeat (60) @(posedge clk_sys);
    chk(n_st, 0);
    bus(1'b1, adc_acq_pkg::REG_CTRL, 32'h1);
    for (int i = 0; i < 16; i++) begin
      getw();
      chk(w, {13'h0, 3'(i), 16'h0100 + 16'(i % 8)});
    end
    bus(1'b1, adc_acq_pkg::REG_CTRL, 32'h2);
    waitst(6'h01);
  endtask : t_cont
  task automatic t_event();
    int m, s0, d;
    for (int e = 0; e < 3; e++) begin
      d = (e == 2) ? 100 : 0;
      bus(1'b1, adc_acq_pkg::REG_DELAY, d);
      bus(1'b1, adc_acq_pkg::REG_NCOUNT, 32'h2);
      bus(1'b1, adc_acq_pkg::REG_MODE, 32'h41 | (e << 2));
      bus(1'b1, adc_acq_pkg::REG_CTRL, 32'h1);
      s0 = n_sc;
      repeat (90) @(posedge clk_sys);
      chk(32'(n_sc != s0), 32'(e == 0));
      pulse(m);
      if (e != 0) chk(32'(m >= d && m <= d + 8), 32'h1);
      waitst(6'h10);
      pulse(m);
      waitst(6'h10);
      s0 = n_st;
      bus(1'b1, adc_acq_pkg::REG_CTRL, 32'h4);
      for (int i = 0; i < 16; i++) begin
        getw();
        chk(w, {16'h0, 16'h0100 + 16'(i % 8)});
      end
      repeat (40) @(posedge clk_sys);
      chk(n_st - s0, 16);
      bus(1'b1, adc_acq_pkg::REG_CTRL, 32'h2);
    end
  endtask : t_event
  task automatic t_thr();
    logic [15:0] lv0 [4] = '{16'h0, 16'h0, 16'h0, 16'h00c8};
    logic [15:0] lv1 [4] = '{16'h00c8, 16'hff38, 16'h00c8, 16'h0};
    bus(1'b1, adc_acq_pkg::REG_THR, 32'h0064_ff9c);
    for (int t = 0; t < 4; t++) begin
      ai_level <= lv0[t];
      bus(1'b1, adc_acq_pkg::REG_MODE, 32'h0c42 | (t << 4));
      bus(1'b1, adc_acq_pkg::REG_CTRL, 32'h1);
      repeat (100) @(posedge clk_sys);
      waitst(6'h02);
      ai_level <= lv1[t];
      waitst(6'h10);
      bus(1'b1, adc_acq_pkg::REG_CTRL, 32'h2);
      waitst(6'h01);
    end
    ai_level <= 16'h0100;
  endtask : t_thr
  task automatic t_cnt();
    int m, c0;
    logic [31:0] l0;
    bus(1'b1, adc_acq_pkg::REG_MODE, 32'h81);
    bus(1'b1, adc_acq_pkg::REG_CTRL, 32'h1);
    bus(1'b0, adc_acq_pkg::REG_STATUS, 32'h0);
    chk(rdq, 32'h101);
    bus(1'b1, adc_acq_pkg::REG_CTRL, 32'h8);
    bus(1'b0, 5'h0d, 32'h0);
    l0 = rdq;
    repeat (3) pulse(m);
    bus(1'b0, 5'h0d, 32'h0);
    chk(rdq, l0 + 32'h3);
    bus(1'b0, adc_acq_pkg::REG_LIVE0, 32'h0);
    l0 = rdq;
    repeat (2) begin
      di_pin <= 4'h1;
      repeat (6) @(posedge clk_sys);
      di_pin <= 4'h0;
      repeat (6) @(posedge clk_sys);
    end
    bus(1'b0, adc_acq_pkg::REG_LIVE0, 32'h0);
    chk(rdq, l0 + 32'h2);
    bus(1'b1, adc_acq_pkg::REG_FRAME, 32'h4);
    bus(1'b1, adc_acq_pkg::REG_MODE, 32'h300);
    bus(1'b1, adc_acq_pkg::REG_CTRL, 32'h1);
    getw();
    chk(w, l0 + 32'h2);
    bus(1'b1, adc_acq_pkg::REG_CTRL, 32'h2);
    bus(1'b0, adc_acq_pkg::REG_LATCH0, 32'h0);
    chk(rdq, l0 + 32'h2);
    bus(1'b1, adc_acq_pkg::REG_MODE, 32'h3);
    bus(1'b1, adc_acq_pkg::REG_CTRL, 32'h1);
    c0 = n_sc;
    repeat (3) pulse(m);
    chk(n_sc - c0, 3);
    bus(1'b1, adc_acq_pkg::REG_CTRL, 32'h2);
  endtask : t_cnt
  // watchdog
  initial begin
    repeat (80000) @(posedge clk_sys);
    err_total++;
    tally_and_finish();
  end
  // main sequence
  initial begin
    srst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 5'h0;
    avs_writedata = 32'h0;
    trig_pin = 1'b1;
    di_pin = 4'h0;
    ai_level = 16'h0100;
    repeat (5) @(posedge clk_sys);
    srst <= 1'b0;
    t_regs();
    t_cont();
    t_event();
    t_thr();
    t_cnt();
    tally_and_finish();
  end
endmodule : tb_adc_acquisition_trigger_control
`default_nettype wire
